// ===== hw/queue_status_registers.sv
//Function
//- Free transmit bytes in low 13 bits
//- Free count resets to full capacity
//- Charge payload and control word per frame
//- Top bit marks valid frame status
//- Valid reads zero when nothing pending
//- Flag bad ICMP checksum
//- Flag bad IP header checksum
//- Flag bad TCP checksum
//- Flag bad UDP checksum
//- Flag broadcast destination
//- Multicast flag also set for broadcast
//- Flag unicast destination
//- Type bit set above maximum payload length
//- Type bit meaningless for runt frames
//- Flag collision-damaged or premature frames
//- Flag frame check sequence failure
//- Bad frames kept only with pass-bad set
//- One status per kept frame while the queue has room, one read each
`timescale 1ns/1ps
`default_nettype none
`include "queue_status_defs.svh"

module queue_status_registers (
  input  wire logic                    CORE_CLK_IN,
  input  wire logic                    RST_N_IN,
  // Parallel host bus
  input  wire logic                    CS_N_IN,
  input  wire logic                    RD_N_IN,
  input  wire logic                    WR_N_IN,
  input  wire logic [`HOST_ADDR_W-1:0] ADDR_IN,
  input  wire logic [`HOST_DATA_W-1:0] DATA_IN,
  output logic      [`HOST_DATA_W-1:0] DATA_OUT,
  output logic                         DATA_OE_N_OUT,
  // Transmit queue accounting events
  input  wire logic                    TX_ALLOC_IN,
  input  wire logic [`TX_FREE_W-1:0]   TX_ALLOC_LEN_IN,
  input  wire logic                    TX_RELEASE_IN,
  input  wire logic [`TX_FREE_W-1:0]   TX_RELEASE_LEN_IN,
  // Receive frame completion and its header results
  input  wire logic                    RX_FRAME_DONE_IN,
  input  wire logic [47:0]             RX_DEST_ADDR_IN,
  input  wire logic [15:0]             RX_LEN_TYPE_IN,
  input  wire logic                    RX_ICMP_CSUM_ERR_IN,
  input  wire logic                    RX_IP_CSUM_ERR_IN,
  input  wire logic                    RX_TCP_CSUM_ERR_IN,
  input  wire logic                    RX_UDP_CSUM_ERR_IN,
  input  wire logic                    RX_RUNT_IN,
  input  wire logic                    RX_CRC_ERR_IN,
  input  wire logic                    PASS_BAD_FRAME_IN,
  output logic                         RX_STATUS_FULL_OUT,
  output logic                         RX_FRAME_PENDING_OUT
);

  status_queue_if stq ();

  queue_status_pkg::bus_state_type state;
  queue_status_pkg::bus_state_type next_state;

  logic [2:0]              strobe_meta;
  logic [2:0]              strobe_sync;
  logic [`HOST_ADDR_W-1:0] addr_meta;
  logic [`HOST_ADDR_W-1:0] addr_sync;
  logic [`HOST_ADDR_W-1:0] read_addr;
  logic [`HOST_DATA_W-1:0] rd_data;
  logic [`HOST_DATA_W-1:0] next_rd_data;
  logic [`TX_FREE_W-1:0]   tx_free_byte_count;
  logic [`TX_FREE_W-1:0]   next_tx_free;
  logic [`TX_FREE_W:0]     charge;
  logic [`TX_FREE_W:0]     credit;
  logic [`TX_FREE_W+1:0]   level;
  logic                    read_active;
  logic                    read_start;
  logic                    read_end;
  logic                    frame_bad;
  logic                    keep_frame;
  logic                    broadcast_dest_flag;
  logic                    multicast_dest_flag;
  logic                    unicast_dest_flag;
  logic                    ethertype_frame_flag;
  queue_status_pkg::status_word_type rx_frame_header_status;

  // DATA_IN is unused: both registers are read-only
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; strobes and address pass two flops before use
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      strobe_meta <= 3'h7;
      strobe_sync <= 3'h7;
    end else begin
      strobe_meta <= {CS_N_IN, RD_N_IN, WR_N_IN};
      strobe_sync <= strobe_meta;
    end
  end

  // Address synchroniser
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      addr_meta <= 12'h000;
      addr_sync <= 12'h000;
    end else begin
      addr_meta <= ADDR_IN;
      addr_sync <= addr_meta;
    end
  end

  // Writes are seen but change nothing here
  assign read_active = !strobe_sync[2] && !strobe_sync[1];

  //////////////////////////////////////////////////////////////////////////////
  // Read sequencer: sample data once at the start so a pop mid-read cannot
  // tear the word the host is looking at
  always_comb begin
    next_state = state;
    case (state)
      queue_status_pkg::BUS_IDLE: begin
        if (read_active) begin
          next_state = queue_status_pkg::BUS_READ;
        end
      end
      queue_status_pkg::BUS_READ: begin
        if (!read_active) begin
          next_state = queue_status_pkg::BUS_IDLE;
        end
      end
      default: begin
        next_state = queue_status_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= queue_status_pkg::BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign read_start = (state == queue_status_pkg::BUS_IDLE) && read_active;
  assign read_end   = (state == queue_status_pkg::BUS_READ) && !read_active;

  // Address held for the whole read cycle
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      read_addr <= 12'h000;
    end else if (read_start) begin
      read_addr <= addr_sync;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data decode; unmapped and reserved locations read zero
  always_comb begin
    next_rd_data = rd_data;
    if (read_start) begin
      if (addr_sync == `TX_FREE_OFFSET) begin
        next_rd_data = {3'h0, tx_free_byte_count};
      end else if (addr_sync == `RX_STATUS_OFFSET) begin
        // Valid only while a completed frame waits
        next_rd_data = stq.not_empty ? stq.head : 16'h0000;
      end else begin
        next_rd_data = 16'h0000;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  assign DATA_OUT      = rd_data;
  assign DATA_OE_N_OUT = (state != queue_status_pkg::BUS_READ);

  //////////////////////////////////////////////////////////////////////////////
  // Transmit free space. Each frame costs its payload plus one control word;
  // the level saturates so a misbehaving writer cannot wrap the count.
  assign charge = TX_ALLOC_IN ? ({1'b0, TX_ALLOC_LEN_IN} + {1'b0, `TX_CTRL_WORD_BYTES})
                              : 14'h0000;
  assign credit = TX_RELEASE_IN ? ({1'b0, TX_RELEASE_LEN_IN} + {1'b0, `TX_CTRL_WORD_BYTES})
                                : 14'h0000;
  assign level  = {2'h0, tx_free_byte_count} + {1'b0, credit} - {1'b0, charge};

  always_comb begin
    if (level[`TX_FREE_W+1]) begin
      next_tx_free = 13'h0000;
    end else if (level > {2'h0, `TX_QUEUE_CAPACITY}) begin
      next_tx_free = `TX_QUEUE_CAPACITY;
    end else begin
      next_tx_free = level[`TX_FREE_W-1:0];
    end
  end

  // Empty queue after reset
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_free_byte_count <= `TX_QUEUE_CAPACITY;
    end else begin
      tx_free_byte_count <= next_tx_free;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive header status built at frame completion
  assign broadcast_dest_flag  = (RX_DEST_ADDR_IN == 48'hffffffffffff);
  // Group bit of the first octet covers broadcast too
  assign multicast_dest_flag  = RX_DEST_ADDR_IN[40];
  assign unicast_dest_flag    = !RX_DEST_ADDR_IN[40];
  // Undefined for runts; the host must ignore it there
  assign ethertype_frame_flag = (RX_LEN_TYPE_IN > `MAX_PAYLOAD_LEN);

  always_comb begin
    rx_frame_header_status = 16'h0000;
    rx_frame_header_status[`ST_VALID_BIT] = 1'b1;
    rx_frame_header_status[`ST_ICMP_BIT]  = RX_ICMP_CSUM_ERR_IN;
    rx_frame_header_status[`ST_IP_BIT]    = RX_IP_CSUM_ERR_IN;
    rx_frame_header_status[`ST_TCP_BIT]   = RX_TCP_CSUM_ERR_IN;
    rx_frame_header_status[`ST_UDP_BIT]   = RX_UDP_CSUM_ERR_IN;
    rx_frame_header_status[`ST_BCAST_BIT] = broadcast_dest_flag;
    rx_frame_header_status[`ST_MCAST_BIT] = multicast_dest_flag;
    rx_frame_header_status[`ST_UCAST_BIT] = unicast_dest_flag;
    rx_frame_header_status[`ST_TYPE_BIT]  = ethertype_frame_flag;
    rx_frame_header_status[`ST_RUNT_BIT]  = RX_RUNT_IN;
    rx_frame_header_status[`ST_CRC_BIT]   = RX_CRC_ERR_IN;
  end

  // Bad frames only reach the host when pass-bad is set
  assign frame_bad  = RX_RUNT_IN || RX_CRC_ERR_IN;
  assign keep_frame = RX_FRAME_DONE_IN && (!frame_bad || PASS_BAD_FRAME_IN);

  // One entry per kept frame while the queue is not full, retired by the read that returned it
  assign stq.push      = keep_frame;
  assign stq.push_data = rx_frame_header_status;
  // Retire only a word the host saw as valid; a frame landing mid-read stays queued
  assign stq.pop       = read_end && (read_addr == `RX_STATUS_OFFSET)
                         && rd_data[`ST_VALID_BIT];

  rx_status_queue u_rx_status_queue (
    .clk   (CORE_CLK_IN),
    .rst_n (RST_N_IN),
    .q     (stq.queue_side)
  );

  assign RX_STATUS_FULL_OUT   = stq.full;
  assign RX_FRAME_PENDING_OUT = stq.not_empty;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_free_reset_value: assert property (
    @(posedge CORE_CLK_IN) $rose(RST_N_IN) |-> tx_free_byte_count == `TX_QUEUE_CAPACITY)
    else $error("free count not at capacity after reset");

  chk_free_charge_step: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (TX_ALLOC_IN && !TX_RELEASE_IN
      && ({1'b0, TX_ALLOC_LEN_IN} + 14'h0004 <= {1'b0, tx_free_byte_count}))
    |=> tx_free_byte_count == $past(tx_free_byte_count) - $past(TX_ALLOC_LEN_IN) - 13'h0004)
    else $error("frame charge against free space wrong");

  chk_free_release_step: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (TX_RELEASE_IN && !TX_ALLOC_IN
      && ({1'b0, TX_RELEASE_LEN_IN} + 14'h0004 + {1'b0, tx_free_byte_count}
          <= {1'b0, `TX_QUEUE_CAPACITY}))
    |=> tx_free_byte_count == $past(tx_free_byte_count) + $past(TX_RELEASE_LEN_IN) + 13'h0004)
    else $error("frame release credit to free space wrong");

  chk_free_in_range: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) tx_free_byte_count <= `TX_QUEUE_CAPACITY)
    else $error("free count above queue capacity");

  chk_free_readback_word: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (read_start && addr_sync == `TX_FREE_OFFSET)
    |=> rd_data == {3'h0, $past(tx_free_byte_count)} ##1 !DATA_OE_N_OUT)
    else $error("free count read back wrong");

  chk_valid_when_empty: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (read_start && addr_sync == `RX_STATUS_OFFSET && !stq.not_empty) |=> rd_data == 16'h0000)
    else $error("status read with no frame is not zero");

  chk_valid_head_word: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (read_start && addr_sync == `RX_STATUS_OFFSET && stq.not_empty)
    |=> rd_data[`ST_VALID_BIT] && rd_data == $past(stq.head))
    else $error("pending frame status not returned");

  chk_csum_flags_map: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    stq.push |-> stq.push_data[`ST_ICMP_BIT:`ST_UDP_BIT]
      == {RX_ICMP_CSUM_ERR_IN, RX_IP_CSUM_ERR_IN, RX_TCP_CSUM_ERR_IN, RX_UDP_CSUM_ERR_IN})
    else $error("checksum flags not stored as seen");

  chk_error_flags_map: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    stq.push |-> stq.push_data[`ST_RUNT_BIT:`ST_CRC_BIT] == {RX_RUNT_IN, RX_CRC_ERR_IN}
      && stq.push_data[`ST_VALID_BIT])
    else $error("runt or crc flag not stored as seen");

  chk_dest_class_map: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    stq.push |-> stq.push_data[`ST_BCAST_BIT] == (RX_DEST_ADDR_IN == 48'hffffffffffff)
      && stq.push_data[`ST_UCAST_BIT] == !RX_DEST_ADDR_IN[40])
    else $error("destination class flags wrong");

  chk_pending_after_keep: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    keep_frame && !stq.full |=> RX_FRAME_PENDING_OUT)
    else $error("kept frame not reported pending");

  chk_bcast_sets_mcast: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    stq.push && stq.push_data[`ST_BCAST_BIT] |-> stq.push_data[`ST_MCAST_BIT]
      && !stq.push_data[`ST_UCAST_BIT])
    else $error("broadcast frame lacks multicast flag");

  chk_type_flag_len: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    stq.push && !RX_RUNT_IN |-> stq.push_data[`ST_TYPE_BIT] == (RX_LEN_TYPE_IN > 16'h05dc))
    else $error("frame type flag disagrees with length");

  chk_bad_frame_drop: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    RX_FRAME_DONE_IN && (RX_RUNT_IN || RX_CRC_ERR_IN) |-> stq.push == PASS_BAD_FRAME_IN)
    else $error("bad frame pass or drop wrong");

  chk_one_pop_read: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    stq.pop |-> $past(state == queue_status_pkg::BUS_READ) ##1 !stq.pop [*2])
    else $error("status retired more than once per read");

  chk_reserved_zero: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (read_start && addr_sync == `RSVD_PAIR_OFFSET) |=> rd_data == 16'h0000)
    else $error("reserved location not zero");

  chk_status_reserved_bits: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (read_start && addr_sync == `RX_STATUS_OFFSET)
    |=> (rd_data & `ST_RESERVED_MASK) == 16'h0000)
    else $error("reserved status bits not zero");

  cov_status_read: cover property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) stq.pop);

  cov_bad_dropped: cover property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    RX_FRAME_DONE_IN && RX_CRC_ERR_IN && !PASS_BAD_FRAME_IN);

  cov_free_charged: cover property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) TX_ALLOC_IN ##[1:20] TX_RELEASE_IN);

  cov_queue_full: cover property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN) stq.full);

endmodule

`default_nettype wire

// ===== hw/queue_status_defs.svh
`ifndef QUEUE_STATUS_DEFS_SVH
`define QUEUE_STATUS_DEFS_SVH

// Host bus geometry
`define HOST_ADDR_W        12
`define HOST_DATA_W        16

// Register byte offsets
`define TX_FREE_OFFSET     12'h178
`define RSVD_PAIR_OFFSET   12'h17a
`define RX_STATUS_OFFSET   12'h17c

// Transmit queue accounting
`define TX_QUEUE_CAPACITY  13'h1800
`define TX_CTRL_WORD_BYTES 13'h004
`define TX_FREE_W          13

// Receive header status field positions
`define ST_VALID_BIT       15
`define ST_ICMP_BIT        13
`define ST_IP_BIT          12
`define ST_TCP_BIT         11
`define ST_UDP_BIT         10
`define ST_BCAST_BIT       7
`define ST_MCAST_BIT       6
`define ST_UCAST_BIT       5
`define ST_TYPE_BIT        3
`define ST_RUNT_BIT        1
`define ST_CRC_BIT         0
`define ST_RESERVED_MASK   16'h4314

// Largest length value that still means a length-encoded frame
`define MAX_PAYLOAD_LEN    16'h05dc

// Status queue geometry
`define STQ_DEPTH          4
`define STQ_PTR_W          2
`define STQ_CNT_W          3

`endif

// ===== hw/queue_status_pkg.sv
package queue_status_pkg;

  // One-hot host read sequencer
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_type;

  typedef logic [15:0] status_word_type;

endpackage

// ===== hw/status_queue_if.sv
`timescale 1ns/1ps
`default_nettype none

interface status_queue_if;
  logic                            push;
  queue_status_pkg::status_word_type push_data;
  logic                            pop;
  queue_status_pkg::status_word_type head;
  logic                            not_empty;
  logic                            full;

  modport owner_side (
    output push,
    output push_data,
    output pop,
    input  head,
    input  not_empty,
    input  full
  );

  modport queue_side (
    input  push,
    input  push_data,
    input  pop,
    output head,
    output not_empty,
    output full
  );
endinterface

`default_nettype wire

// ===== hw/rx_status_queue.sv
`timescale 1ns/1ps
`default_nettype none
`include "queue_status_defs.svh"

module rx_status_queue (
  input  wire logic           clk,
  input  wire logic           rst_n,
  status_queue_if.queue_side  q
);

  queue_status_pkg::status_word_type entry [`STQ_DEPTH];
  logic [`STQ_PTR_W-1:0] wr_ptr;
  logic [`STQ_PTR_W-1:0] rd_ptr;
  logic [`STQ_CNT_W-1:0] count;
  logic                  do_push;
  logic                  do_pop;

  // A push into a full queue is refused; the receive side must hold off
  assign do_push = q.push && !q.full;
  assign do_pop  = q.pop && q.not_empty;

  //////////////////////////////////////////////////////////////////////////////
  // Storage, one flip-flop word per entry
  genvar i;
  generate
    for (i = 0; i < `STQ_DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          entry[i] <= 16'h0000;
        end else if (do_push && (int'(wr_ptr) == i)) begin
          entry[i] <= q.push_data;
        end
      end
    end
  endgenerate

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      if (do_push && !do_pop) begin
        count <= count + 3'h1;
      end else if (do_pop && !do_push) begin
        count <= count - 3'h1;
      end
    end
  end

  assign q.head      = entry[rd_ptr];
  assign q.not_empty = (count != 3'h0);
  assign q.full      = (count == 3'h4);

endmodule

`default_nettype wire

// ===== dv/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "queue_status_defs.svh"

module host_bus_model (
  input  wire logic                    clk,
  input  wire logic [`HOST_DATA_W-1:0] data_out,
  input  wire logic                    data_oe_n,
  output logic                         cs_n,
  output logic                         rd_n,
  output logic                         wr_n,
  output logic      [`HOST_ADDR_W-1:0] addr,
  output logic      [`HOST_DATA_W-1:0] data
);
  // Bus idles deselected; released data shows the inverse of the last word
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 12'h000;
    data = 16'h5a5a;
  end

  // Strobes held until the enable is seen low, then released with a gap
  task automatic read_reg(input logic [`HOST_ADDR_W-1:0] a, output logic [`HOST_DATA_W-1:0] d,
                          output logic ok);
    int n;
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    for (n = 0; n < 10 && !ok; n++) begin
      @(posedge clk);
      #1;
      if (data_oe_n === 1'b0) begin
        ok = 1'b1;
        d = data_out;
      end
    end
    cs_n = 1'b1;
    rd_n = 1'b1;
    addr = ~a;
    for (n = 0; n < 10 && data_oe_n !== 1'b1; n++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  // No handshake on writes, so the strobe stands a fixed few cycles
  task automatic write_reg(input logic [`HOST_ADDR_W-1:0] a, input logic [`HOST_DATA_W-1:0] d);
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    data = d;
    repeat (4) @(posedge clk);
    #1;
    cs_n = 1'b1;
    wr_n = 1'b1;
    data = ~d;
    repeat (3) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// ===== dv/queue_status_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "queue_status_defs.svh"

module queue_status_registers_tb_top;
  logic        clk;
  logic        rst_n;
  logic        cs_n, rd_n, wr_n, oe_n;
  logic [11:0] addr;
  logic [15:0] din, dout;
  logic        alloc, rel, done, pass_bad, full, pending;
  logic [12:0] alloc_len, rel_len;
  logic [47:0] dest;
  logic [15:0] len_type;
  logic [5:0]  flags;
  logic [31:0] seed = 32'h0000089b;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;
  int          free = 16'h1800;
  int          outq[$];
  logic [15:0] stq[$];

  ////////////////////////////////////////
  queue_status_registers u_queue_status_registers (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CS_N_IN(cs_n), .RD_N_IN(rd_n),
    .WR_N_IN(wr_n), .ADDR_IN(addr), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE_N_OUT(oe_n), .TX_ALLOC_IN(alloc), .TX_ALLOC_LEN_IN(alloc_len),
    .TX_RELEASE_IN(rel), .TX_RELEASE_LEN_IN(rel_len), .RX_FRAME_DONE_IN(done),
    .RX_DEST_ADDR_IN(dest), .RX_LEN_TYPE_IN(len_type),
    .RX_ICMP_CSUM_ERR_IN(flags[5]), .RX_IP_CSUM_ERR_IN(flags[4]),
    .RX_TCP_CSUM_ERR_IN(flags[3]), .RX_UDP_CSUM_ERR_IN(flags[2]),
    .RX_RUNT_IN(flags[1]), .RX_CRC_ERR_IN(flags[0]), .PASS_BAD_FRAME_IN(pass_bad),
    .RX_STATUS_FULL_OUT(full), .RX_FRAME_PENDING_OUT(pending));

  host_bus_model u_host_bus_model (
    .clk(clk), .data_out(dout), .data_oe_n(oe_n), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data(din));

  // Clock and a hang guard sized well above the planned traffic
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Status word built from the frame's header results
  function automatic logic [15:0] exp_status(input logic [47:0] da, input logic [15:0] lt,
                                             input logic [5:0] f);
    return {1'b1, 1'b0, f[5:2], 2'b00, da == 48'hffffffffffff, da[40], !da[40], 1'b0,
            lt > 16'h05dc, 1'b0, f[1:0]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    logic ok;
    u_host_bus_model.read_reg(a, d, ok);
    check("read_answer", {15'h0000, ok}, 16'h0001);
  endtask

  // Queue accounting events; lengths freed are those charged earlier
  task automatic tx(input logic a, input logic [12:0] al, input logic r, input logic [12:0] rl);
    @(posedge clk);
    #1;
    alloc = a;
    alloc_len = al;
    rel = r;
    rel_len = rl;
    @(posedge clk);
    #1;
    alloc = 1'b0;
    rel = 1'b0;
    free = free + (r ? rl + 4 : 0) - (a ? al + 4 : 0);
  endtask

  task automatic frame(input logic [47:0] da, input logic [15:0] lt, input logic [5:0] f,
                       input logic pb);
    @(posedge clk);
    #1;
    done = 1'b1;
    dest = da;
    len_type = lt;
    flags = f;
    pass_bad = pb;
    @(posedge clk);
    #1;
    done = 1'b0;
    dest = ~da;
    flags = ~f;
    if ((f[1:0] == 2'b00 || pb) && stq.size() < 4) stq.push_back(exp_status(da, lt, f));
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    logic [15:0] d, e;
    logic [12:0] len;
    logic [47:0] da;
    logic        pb;
    {alloc, rel, done, pass_bad} = 4'h0;
    {alloc_len, rel_len, len_type, flags} = '0;
    dest = 48'h000000000000;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // Reset state, reserved places and ignored writes
    check("pending", {15'h0000, pending}, 16'h0000);
    rd(12'h178, d);
    check("tx_free", d, 16'h1800);
    rd(12'h17c, d);
    check("rx_valid", {15'h0000, d[15]}, 16'h0000);
    rd(12'h17a, d);
    check("reserved_pair", d, 16'h0000);
    rd(12'h000, d);
    check("unmapped", d, 16'h0000);
    u_host_bus_model.write_reg(12'h178, 16'h0123);
    rd(12'h178, d);
    check("tx_free_after_write", d, 16'h1800);
    $display("test reset done");
    // Random allocations and releases, sometimes in the same cycle
    for (int i = 0; i < 24; i++) begin
      len = 13'(rnd() % 1500);
      pb = rnd() % 3 != 0 && outq.size() > 0;
      if (free >= len + 4) outq.push_back(len);
      tx(free >= len + 4, len, pb, pb ? 13'(outq[0]) : 13'h0000);
      if (pb) void'(outq.pop_front());
      rd(12'h178, d);
      check("tx_free", d, 16'(free));
    end
    $display("test tx accounting done");
    // Frames of every class, flags one by one, then random ones in bursts
    for (int i = 0; i < 24; i++) begin
      case (i % 4)
        0: da = 48'hffffffffffff;
        1: da = 48'h01005e000001;
        2: da = 48'h00123456789a;
        default: da = 48'({rnd(), rnd()}) & 48'hfeffffffffff;
      endcase
      frame(da, (i % 2) ? 16'h05dc : 16'h05dd, i < 6 ? 6'h01 << i : 6'(rnd()),
            i < 6 ? 1'b1 : 1'(rnd()));
      check("pending", {15'h0000, pending}, {15'h0000, stq.size() > 0});
      check("full", {15'h0000, full}, {15'h0000, stq.size() == 4});
      if (i % 6 == 5) begin
        while (stq.size() > 0) begin
          rd(12'h17c, d);
          e = stq.pop_front();
          if (e[1]) e[3] = d[3];
          check("rx_status", d, e);
        end
        rd(12'h17c, d);
        check("rx_valid_drained", {15'h0000, d[15]}, 16'h0000);
      end
    end
    $display("test rx status done");
    summarize();
  end
endmodule

`default_nettype wire
